/* rtl/clkbuf_params.svh */
// Holds every offset, field position, reset value and timing count of the clock buffer control.
// Assumes inclusion by bare name from the design file and the bench.
`ifndef CLKBUF_PARAMS_SVH
`define CLKBUF_PARAMS_SVH
// ==========================================================
// Register map (byte addresses on the AHB-Lite slave).
`define REG_MODE_CTRL       12'h000
`define REG_STATUS          12'h004
`define REG_SUPPLY_CTRL     12'h008
// ==========================================================
// Field positions of the mode control register.
`define FLD_FREQ_SEL        0
`define FLD_SW_MODE0        1
`define FLD_SW_MODE1        2
`define FLD_SW_ENABLE       3
`define FLD_LATCH_MODE0     6
`define FLD_LATCH_MODE1     7
`define MODE_CTRL_RESET     8'h06
// ==========================================================
// Serial management addresses selected by the address straps (high strap first).
`define ADDR_LL             8'hd8
`define ADDR_LM             8'hda
`define ADDR_LH             8'hde
`define ADDR_ML             8'hc2
`define ADDR_MM             8'hc4
`define ADDR_MH             8'hc6
`define ADDR_HL             8'hca
`define ADDR_HM             8'hcc
`define ADDR_HH             8'hce
// ==========================================================
// Timing in its own unit and the clock rate.
`define CLK_MHZ             50
`define SETTLE_DELAY_NS     100000
`define LOCK_LIMIT_NS       1800000
`define RESTART_LIMIT_NS    300000
`define STRETCH_LIMIT_NS    10000000
`define CLK_PERIOD_NS       20
`define SETTLE_CYCLES       ((`SETTLE_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define LOCK_LIMIT_CYCLES   (`LOCK_LIMIT_NS / `CLK_PERIOD_NS)
`define RESTART_CYCLES      (`RESTART_LIMIT_NS / `CLK_PERIOD_NS)
`define STRETCH_CYCLES      (`STRETCH_LIMIT_NS / `CLK_PERIOD_NS)
`define LOCK_WAIT_CYCLES    64
`endif

/* rtl/clkbuf_pkg.sv */
// Holds the types of the clock buffer control.
// Assumes the parameter header is on the include path.
package clkbuf_pkg;
   // Three-level strap reading.
   typedef enum logic [1:0] {LVL_LOW, LVL_MID, LVL_HIGH} level_t;
   // Power-up sequence states.
   typedef enum logic [1:0] {ST_POWER_OFF, ST_SETTLE, ST_WAIT_CLK, ST_RUNNING} pwr_state_t;
   // PLL operating modes.
   typedef enum logic [1:0] {PLL_LOW_BW, PLL_BYPASS, PLL_HIGH_BW} pll_mode_t;
endpackage

/* rtl/clock_buffer_power_strap_control.sv */
// Holds the power, strap and sequencing control of a twelve-output differential clock buffer.
// Assumes hclk at 50 MHz, an AHB-Lite master, and asynchronous pins that are synchronised here.
`timescale 1ns/1ps
`include "clkbuf_params.svh"

module clock_buffer_power_strap_control
   import clkbuf_pkg::*;
#(
   parameter int NUM_OUTPUTS   = 12,                   // Differential outputs.
   parameter int SETTLE_CYC    = `SETTLE_CYCLES,       // Settle delay after supply detect.
   parameter int LOCK_WAIT     = `LOCK_WAIT_CYCLES,    // Stable link clock edges taken as PLL lock.
   parameter int STRETCH_CYC   = `STRETCH_CYCLES       // Longest hold of a management line.
) (
   input  wire logic                   hclk,
   input  wire logic                   hresetn,
   input  wire logic                   hsel,
   input  wire logic [11:0]            haddr,
   input  wire logic [1:0]             htrans,
   input  wire logic                   hwrite,
   input  wire logic [2:0]             hsize,
   input  wire logic [31:0]            hwdata,
   input  wire logic                   hready,
   output logic      [31:0]            hrdata,
   output logic                        hreadyout,
   output logic                        hresp,
   input  wire logic                   supply_ok,
   input  wire logic                   power_good_in,
   input  wire logic                   ref_clk_in,
   input  wire logic                   freq_select_strap,
   input  wire logic [1:0]             addr_strap_low,
   input  wire logic [1:0]             addr_strap_high,
   input  wire logic [1:0]             pll_bw_strap,
   input  wire logic                   mgmt_clk_in,
   input  wire logic                   mgmt_data_pin_in,
   output logic                        mgmt_data_pin_out,
   output logic                        mgmt_data_pin_oe,
   output logic                        mgmt_clk_oe,
   output logic [NUM_OUTPUTS-1:0]      diff_clk_out_p,
   output logic [NUM_OUTPUTS-1:0]      diff_clk_out_n,
   output logic                        vco_enable,
   output logic                        pll_bypass,
   output logic                        pll_high_bandwidth,
   output logic                        pll_low_bandwidth,
   output logic                        freq_is_100m,
   output logic [7:0]                  mgmt_address
);

   // ==========================================================
   // Elaboration check.
   initial begin
      if (NUM_OUTPUTS < 1 || NUM_OUTPUTS > 32 || SETTLE_CYC < 1 || LOCK_WAIT < 2 || STRETCH_CYC < 1) begin
         $error("clock_buffer_power_strap_control: unsupported parameter value");
      end
   end

   // ==========================================================
   // Functions.

   // Maps a two-bit pin code to a three-level reading; code 2'b11 is high, 2'b01 middle.
   function automatic level_t to_level(input logic [1:0] code);
      level_t lvl;
      lvl = LVL_LOW;
      if (code == 2'h3) begin
         lvl = LVL_HIGH;
      end else if (code == 2'h1 || code == 2'h2) begin
         lvl = LVL_MID;
      end
      return lvl;
   endfunction

   // Decodes the address straps, high strap first.
   function automatic logic [7:0] decode_addr(input level_t hi, input level_t lo);
      logic [7:0] a;
      a = `ADDR_LL;
      case ({hi, lo})
         {LVL_LOW,  LVL_LOW}:  a = `ADDR_LL;
         {LVL_LOW,  LVL_MID}:  a = `ADDR_LM;
         {LVL_LOW,  LVL_HIGH}: a = `ADDR_LH;
         {LVL_MID,  LVL_LOW}:  a = `ADDR_ML;
         {LVL_MID,  LVL_MID}:  a = `ADDR_MM;
         {LVL_MID,  LVL_HIGH}: a = `ADDR_MH;
         {LVL_HIGH, LVL_LOW}:  a = `ADDR_HL;
         {LVL_HIGH, LVL_MID}:  a = `ADDR_HM;
         default:              a = `ADDR_HH;
      endcase
      return a;
   endfunction

   // ==========================================================
   // Synchronisers: three flops, a change counts when the last two agree.
   localparam int NSYNC = 5;
   logic [NSYNC-1:0] async_in;   // Raw asynchronous inputs.
   logic [NSYNC-1:0] sync1;      // First stage, read only by the second.
   logic [NSYNC-1:0] sync2;      // Second stage.
   logic [NSYNC-1:0] sync3;      // Third stage.
   logic [NSYNC-1:0] clean;      // Filtered levels.

   assign async_in = {mgmt_data_pin_in, mgmt_clk_in, ref_clk_in, power_good_in, supply_ok};

   // Shifts the raw pins through three flops.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         sync1 <= '0;
         sync2 <= '0;
         sync3 <= '0;
      end else begin
         sync1 <= async_in;
         sync2 <= sync1;
         sync3 <= sync2;
      end
   end

   // Updates each filtered level only when stages two and three agree.
   genvar gi;
   generate
      for (gi = 0; gi < NSYNC; gi++) begin : g_filt
         always_ff @(posedge hclk or negedge hresetn) begin
            if (!hresetn) begin
               clean[gi] <= 1'b0;
            end else if (sync2[gi] == sync3[gi]) begin
               clean[gi] <= sync3[gi];
            end
         end
      end
   endgenerate

   logic supply_s;   // Supply detected.
   logic pgood_s;    // Power-good or power-down level.
   logic ref_s;      // Sampled reference clock.
   logic ref_prev;   // Previous reference sample.
   logic ref_rise;   // Reference rising edge.
   logic ref_fall;   // Reference falling edge.
   assign supply_s = clean[0];
   assign pgood_s  = clean[1];
   assign ref_s    = clean[2];
   assign ref_rise = ref_s & ~ref_prev;
   assign ref_fall = ~ref_s & ref_prev;

   // Keeps the last reference sample for edge detection.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ref_prev <= 1'b0;
      end else begin
         ref_prev <= ref_s;
      end
   end

   // ==========================================================
   // Strap capture.
   logic       straps_taken;   // Set at the first power-good rise.
   logic       freq_strap;     // Captured frequency strap.
   logic [7:0] addr_latch;     // Captured bus address.
   pll_mode_t  strap_mode;     // Captured PLL mode.

   // Captures the straps once, at the first power-good assertion, until supply is lost.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         straps_taken <= 1'b0;
         freq_strap   <= 1'b0;
         addr_latch   <= `ADDR_LL;
         strap_mode   <= PLL_LOW_BW;
      end else if (!supply_s) begin
         straps_taken <= 1'b0;
      end else if (pgood_s && !straps_taken) begin
         straps_taken <= 1'b1;
         freq_strap   <= freq_select_strap;
         addr_latch   <= decode_addr(to_level(addr_strap_high), to_level(addr_strap_low));
         case (to_level(pll_bw_strap))
            LVL_LOW: strap_mode <= PLL_LOW_BW;
            LVL_MID: strap_mode <= PLL_BYPASS;
            default: strap_mode <= PLL_HIGH_BW;
         endcase
      end
   end

   // ==========================================================
   // Mode control register: software override bits and readback.
   logic [7:0] mode_ctrl;       // Bits 3:1 written by software.
   logic [1:0] latch_readback;  // Bits 7:6 for the latched mode.
   pll_mode_t  active_mode;     // Mode applied at the last warm reset.
   logic       pgood_prev;      // Previous power-good level.

   always_comb begin
      case (strap_mode)
         PLL_LOW_BW: latch_readback = 2'h0;
         PLL_BYPASS: latch_readback = 2'h1;
         default:    latch_readback = 2'h3;
      endcase
   end

   // Applies strap or software mode on each power-good rise, which is the warm reset.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pgood_prev  <= 1'b0;
         active_mode <= PLL_LOW_BW;
      end else begin
         pgood_prev <= pgood_s;
         if (pgood_s && !pgood_prev) begin
            if (straps_taken && mode_ctrl[`FLD_SW_ENABLE]) begin
               case ({mode_ctrl[`FLD_SW_MODE1], mode_ctrl[`FLD_SW_MODE0]})
                  2'h0:    active_mode <= PLL_LOW_BW;
                  2'h1:    active_mode <= PLL_BYPASS;
                  default: active_mode <= PLL_HIGH_BW;
               endcase
            end else if (straps_taken) begin
               active_mode <= strap_mode;
            end else begin
               case (to_level(pll_bw_strap))
                  LVL_LOW: active_mode <= PLL_LOW_BW;
                  LVL_MID: active_mode <= PLL_BYPASS;
                  default: active_mode <= PLL_HIGH_BW;
               endcase
            end
         end
      end
   end

   // Drives the PLL path selection from flops.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pll_bypass         <= 1'b0;
         pll_high_bandwidth <= 1'b0;
         pll_low_bandwidth  <= 1'b0;
         freq_is_100m       <= 1'b0;
         mgmt_address       <= `ADDR_LL;
      end else begin
         pll_bypass         <= (active_mode == PLL_BYPASS);
         pll_high_bandwidth <= (active_mode == PLL_HIGH_BW);
         pll_low_bandwidth  <= (active_mode == PLL_LOW_BW);
         freq_is_100m       <= freq_strap;
         mgmt_address       <= addr_latch;
      end
   end

   // ==========================================================
   // Power-up sequence.
   pwr_state_t state;          // Power-up state.
   logic [31:0] seq_count;     // Settle and lock counter.
   logic [1:0]  low_samples;   // Power-down low samples on reference rises.
   logic        outputs_on;    // Output stage enable.
   logic        out_stop;      // Stop request, taken at a falling edge.

   // Steps through power off, settle, wait for clock and release, then run.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         state     <= ST_POWER_OFF;
         seq_count <= '0;
      end else if (!supply_s) begin
         state     <= ST_POWER_OFF;
         seq_count <= '0;
      end else begin
         case (state)
            ST_POWER_OFF: begin
               state     <= ST_SETTLE;
               seq_count <= '0;
            end
            ST_SETTLE: begin
               if (seq_count >= 32'(SETTLE_CYC - 1)) begin
                  state     <= ST_WAIT_CLK;
                  seq_count <= '0;
               end else begin
                  seq_count <= seq_count + 32'h1;
               end
            end
            ST_WAIT_CLK: begin
               // Counts reference edges as lock; a dead clock never locks.
               if (!pgood_s) begin
                  seq_count <= '0;
               end else if (ref_rise) begin
                  if (seq_count >= 32'(LOCK_WAIT - 1)) begin
                     state     <= ST_RUNNING;
                     seq_count <= '0;
                  end else begin
                     seq_count <= seq_count + 32'h1;
                  end
               end
            end
            default: begin
               // Returns to wait for clock only after the outputs have been stopped.
               if (!pgood_s && !outputs_on) begin
                  state     <= ST_WAIT_CLK;
                  seq_count <= '0;
               end
            end
         endcase
      end
   end

   // Counts power-down low samples on reference rising edges.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         low_samples <= '0;
         out_stop    <= 1'b1;
      end else begin
         if (pgood_s) begin
            low_samples <= '0;
            out_stop    <= 1'b0;
         end else if (ref_rise && low_samples != 2'h2) begin
            low_samples <= low_samples + 2'h1;
         end
         if (!pgood_s && ref_rise && low_samples == 2'h1) begin
            out_stop <= 1'b1;
         end
      end
   end

   // Switches the output stage on a reference falling edge, leaving a one-cycle runt on the n legs at turn-off; clears it at once in power off and settle.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         outputs_on <= 1'b0;
      end else if (state != ST_RUNNING && state != ST_WAIT_CLK) begin
         outputs_on <= 1'b0;
      end else if (ref_fall) begin
         outputs_on <= (state == ST_RUNNING) && !out_stop;
      end
   end

   // Keeps the VCO running until the legs have been low a full cycle; starts it after strap capture.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         vco_enable <= 1'b0;
      end else begin
         vco_enable <= (state == ST_WAIT_CLK && pgood_s && straps_taken) || state == ST_RUNNING
                       || outputs_on || (diff_clk_out_p | diff_clk_out_n) != '0;
      end
   end

   // Drives the differential legs; disabled legs are both low.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         diff_clk_out_p <= '0;
         diff_clk_out_n <= '0;
      end else if (outputs_on) begin
         diff_clk_out_p <= {NUM_OUTPUTS{ref_s}};
         diff_clk_out_n <= {NUM_OUTPUTS{~ref_s}};
      end else begin
         diff_clk_out_p <= '0;
         diff_clk_out_n <= '0;
      end
   end

   // ==========================================================
   // Management pins: this block never drives them low, so it never stretches.
   logic [31:0] hold_count;   // Watchdog on any local hold of a line.
   logic        hold_req;     // No transfer logic here, so no hold is requested.
   assign hold_req = 1'b0;

   // Releases the lines after the stretch limit even if a hold were requested.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hold_count <= '0;
      end else if (hold_req && hold_count < 32'(STRETCH_CYC)) begin
         hold_count <= hold_count + 32'h1;
      end else if (!hold_req) begin
         hold_count <= '0;
      end
   end

   // Keeps the lines released while powered down.
   assign mgmt_data_pin_out = 1'b0;
   assign mgmt_data_pin_oe  = hold_req && pgood_s && (hold_count < 32'(STRETCH_CYC));
   assign mgmt_clk_oe       = 1'b0;

   // ==========================================================
   // AHB-Lite slave: zero wait states, OKAY response.
   logic        dp_valid;   // Data phase pending.
   logic        dp_write;   // Pending transfer writes.
   logic [11:0] dp_addr;    // Pending address.

   assign hreadyout = 1'b1;
   assign hresp     = 1'b0;

   // Registers the address phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         dp_valid <= 1'b0;
         dp_write <= 1'b0;
         dp_addr  <= '0;
      end else if (hready) begin
         dp_valid <= hsel && htrans[1];
         dp_write <= hwrite;
         dp_addr  <= haddr;
      end
   end

   // Stores software writes; only bits 3:1 are writable, kept through power-down.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         mode_ctrl <= `MODE_CTRL_RESET;
      end else if (dp_valid && dp_write && dp_addr == `REG_MODE_CTRL) begin
         mode_ctrl <= {4'h0, hwdata[3:1], 1'b0};
      end
   end

   // Returns read data in the cycle after the address phase.
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata <= '0;
      end else if (hready && hsel && htrans[1] && !hwrite) begin
         if (haddr == `REG_MODE_CTRL) begin
            hrdata <= {24'h0, latch_readback, 2'h0, mode_ctrl[3:1], freq_strap};
         end else if (haddr == `REG_STATUS) begin
            hrdata <= {16'h0, mgmt_address, 2'h0, straps_taken, outputs_on, vco_enable,
                       pgood_s, state};
         end else begin
            hrdata <= '0;
         end
      end
   end

endmodule

/* tb/clkbuf_checker_properties.sv */
// Concurrent checks on the ports of the clock buffer control.
// Assumes it is bound into the control block by the statement at its foot.
`timescale 1ns/1ps
module clkbuf_checker #(
   parameter int NUM_OUTPUTS = 12 // Number of differential outputs.
) (
   input wire logic                   hclk,
   input wire logic                   hresetn,
   input wire logic                   hreadyout,
   input wire logic                   hresp,
   input wire logic                   supply_ok,
   input wire logic                   power_good_in,
   input wire logic                   mgmt_data_pin_oe,
   input wire logic                   mgmt_clk_oe,
   input wire logic [NUM_OUTPUTS-1:0] diff_clk_out_p,
   input wire logic [NUM_OUTPUTS-1:0] diff_clk_out_n,
   input wire logic                   vco_enable,
   input wire logic                   pll_bypass,
   input wire logic                   pll_high_bandwidth,
   input wire logic                   pll_low_bandwidth,
   input wire logic                   freq_is_100m,
   input wire logic [7:0]             mgmt_address
);
   // ==========================================================
   // Every check runs on the bus clock and rests during reset.
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   wire legs_low = (diff_clk_out_p == '0) && (diff_clk_out_n == '0); // All legs of all outputs low.
   // ==========================================================
   // Assertions.
   a_bus_always_okay: assert property (hreadyout && !hresp)
      else $error("bus slave not ready or not okay");
   a_mgmt_lines_free: assert property (!mgmt_data_pin_oe && !mgmt_clk_oe)
      else $error("management line driven");
   a_pd_legs_low: assert property ($fell(power_good_in) ##1 !power_good_in [*8] |-> ##[0:60] legs_low [*8])
      else $error("outputs not held low in power-down");
   a_vco_after_legs: assert property ($fell(vco_enable) |-> legs_low && $past(legs_low))
      else $error("vco stopped while outputs ran");
   a_outputs_need_vco: assert property (!legs_low |-> vco_enable)
      else $error("outputs on without vco");
   a_mode_one_hot: assert property ($rose(vco_enable) |-> $onehot({pll_bypass, pll_high_bandwidth, pll_low_bandwidth}))
      else $error("pll mode not one-hot");
   a_straps_held: assert property (vco_enable && $past(vco_enable) |-> $stable(mgmt_address) && $stable(freq_is_100m))
      else $error("captured strap value moved");
   a_restart_bound: assert property ($rose(power_good_in) ##1 (power_good_in && supply_ok) [*8] |-> ##[0:900] !legs_low)
      else $error("outputs did not start in time");
   // Main scenarios reached.
   c_power_down: cover property ($fell(power_good_in));
   c_vco_stop: cover property ($fell(vco_enable));
   c_bypass_running: cover property (pll_bypass && !legs_low);
endmodule
bind clock_buffer_power_strap_control clkbuf_checker #(.NUM_OUTPUTS(NUM_OUTPUTS)) i_clkbuf_checker (.*);

/* tb/clkbuf_partner.sv */
// Platform-side model: the reference clock source and the pulled-up management lines.
// Assumes the bench gates the reference clock and sequences supply and power-good itself.
`timescale 1ns/1ps
module clkbuf_partner (
   input  wire logic ref_run,
   input  wire logic mgmt_data_pin_oe,
   input  wire logic mgmt_data_pin_out,
   input  wire logic mgmt_clk_oe,
   output logic      ref_clk_in,
   output logic      mgmt_clk_in,
   output logic      mgmt_data_pin_in
);
   // ==========================================================
   // Reference clock of 160 ns, off the bus clock's phase, parked low while stopped.
   initial begin
      ref_clk_in = 1'b0;
      #3;
      forever #80 ref_clk_in = ref_run ? ~ref_clk_in : 1'b0;
   end
   // Open-drain lines with pull-ups: high unless the block pulls them down.
   assign mgmt_clk_in = mgmt_clk_oe ? 1'b0 : 1'b1;
   assign mgmt_data_pin_in = (mgmt_data_pin_oe && !mgmt_data_pin_out) ? 1'b0 : 1'b1;
endmodule

/* tb/clock_buffer_power_strap_control_bench.sv */
// Self-checking bench of the clock buffer control: straps, power sequence, override, bus.
// Assumes the partner model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`include "clkbuf_params.svh"
module clock_buffer_power_strap_control_bench;
   // ==========================================================
   // Port signals; those the bench itself drives are given a value at time zero.
   logic        hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, supply_ok = 1'b0, power_good_in = 1'b0;
   logic        freq_select_strap = 1'b0, ref_run = 1'b0, rd_phase = 1'b0;
   logic [1:0]  htrans = '0, addr_strap_low = '0, addr_strap_high = '0, pll_bw_strap = '0;
   logic [2:0]  hsize = 3'h2;
   logic [11:0] haddr = '0, diff_clk_out_p, diff_clk_out_n;
   logic [31:0] hwdata = '0, hrdata, seed = 32'h3d5d8f2e;
   logic [31:0] exp_q[$], msk_q[$]; // Expected read data and masks, oldest first.
   logic        hreadyout, hresp, ref_clk_in, mgmt_clk_in, mgmt_data_pin_in, mgmt_data_pin_out, mgmt_data_pin_oe;
   logic        mgmt_clk_oe, vco_enable, pll_bypass, pll_high_bandwidth, pll_low_bandwidth, freq_is_100m;
   logic [7:0]  mgmt_address;
   logic [7:0]  addr_tab[9] = '{`ADDR_LL, `ADDR_LM, `ADDR_LH, `ADDR_ML, `ADDR_MM, `ADDR_MH, `ADDR_HL, `ADDR_HM, `ADDR_HH};
   wire         hready = hreadyout; // The only slave closes every transfer.
   int          n_fail = 0, check_count = 0;
   always #10 hclk = ~hclk;
   clock_buffer_power_strap_control #(.SETTLE_CYC(10), .LOCK_WAIT(4), .STRETCH_CYC(16))
      i_clock_buffer_power_strap_control (.*);
   clkbuf_partner i_clkbuf_partner (.*);
   // ==========================================================
   // Helpers: random source, strap coding, compare, bus cycle, waits.
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   // Middle level takes either of its two codes at random.
   function automatic logic [1:0] enc(input int lvl);
      if (lvl == 1) return ((rnd() & 32'h1) != 0) ? 2'b01 : 2'b10;
      return (lvl == 0) ? 2'b00 : 2'b11;
   endfunction
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         n_fail++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   // One single transfer; a read notes its expected word for the monitor.
   task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] m);
      hsel <= 1'b1;
      htrans <= 2'b10;
      haddr <= a;
      hwrite <= wr;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      if (!wr) begin
         exp_q.push_back(d);
         msk_q.push_back(m);
      end
      do @(posedge hclk); while (hready !== 1'b1);
   endtask
   task automatic await_on(input int lim);
      int k;
      k = 0;
      while (diff_clk_out_p === '0 && k < lim) begin
         @(posedge hclk);
         k++;
      end
      chk("outputs running", 1, k < lim);
   endtask
   task automatic hold_off(input string what);
      logic bad;
      bad = 1'b0;
      repeat (40) begin
         @(posedge hclk);
         bad = bad | ((diff_clk_out_p | diff_clk_out_n) != '0);
      end
      chk(what, 0, bad);
   endtask
   // Full power cycle with new straps; power-down always goes first.
   task automatic power_cycle(input int hi, input int lo, input logic f, input logic run);
      power_good_in <= 1'b0;
      repeat (100) @(posedge hclk);
      supply_ok <= 1'b0;
      ref_run <= 1'b0;
      repeat (10) @(posedge hclk);
      addr_strap_high <= enc(hi);
      addr_strap_low <= enc(lo);
      pll_bw_strap <= enc(lo);
      freq_select_strap <= f;
      supply_ok <= 1'b1;
      ref_run <= run;
      repeat (30) @(posedge hclk);
      power_good_in <= 1'b1;
   endtask
   // Takes the oldest note off the queues when a read's data phase closes.
   always @(posedge hclk) begin
      if (rd_phase && hready) begin
         chk("read data", exp_q[0] & msk_q[0], hrdata & msk_q[0]);
         void'(exp_q.pop_front());
         void'(msk_q.pop_front());
      end
      if (hready) rd_phase <= hsel && htrans[1] && !hwrite;
   end
   // ==========================================================
   // Main sequence.
   initial begin
      repeat (4) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      ahb(1'b0, `REG_MODE_CTRL, 32'h06, 32'h0e);
      ahb(1'b1, `REG_SUPPLY_CTRL, rnd(), '0);
      ahb(1'b0, `REG_SUPPLY_CTRL, '0, '1);
      for (int i = 0; i < 9; i++) begin
         power_cycle(i / 3, i % 3, i[0], 1'b1);
         await_on(900);
         addr_strap_high <= enc(2 - i / 3);
         addr_strap_low <= enc(2 - i % 3);
         pll_bw_strap <= enc(2 - i % 3);
         freq_select_strap <= ~i[0];
         repeat (10) @(posedge hclk);
         chk("address", addr_tab[i], mgmt_address);
         chk("frequency", i[0], freq_is_100m);
         chk("pll mode", 3'b100 >> (i % 3), {pll_low_bandwidth, pll_bypass, pll_high_bandwidth});
         ahb(1'b0, `REG_MODE_CTRL, {i % 3 == 2, i % 3 != 0, 5'h03, i[0]}, 32'hcf);
         ahb(1'b0, `REG_STATUS, {addr_tab[i], 8'h3f}, 32'hff3f);
      end
      ahb(1'b1, `REG_MODE_CTRL, 32'h0b, '0);
      ahb(1'b0, `REG_MODE_CTRL, 32'hca, 32'hcf);
      power_good_in <= 1'b0;
      repeat (60) @(posedge hclk);
      hold_off("power-down legs");
      chk("vco stopped", 0, vco_enable);
      chk("mgmt lines", 0, {mgmt_data_pin_oe, mgmt_clk_oe});
      ahb(1'b0, `REG_MODE_CTRL, 32'hca, 32'hcf);
      power_good_in <= 1'b1;
      await_on(`RESTART_CYCLES);
      repeat (10) @(posedge hclk);
      chk("override mode", 3'b010, {pll_low_bandwidth, pll_bypass, pll_high_bandwidth});
      ahb(1'b1, `REG_MODE_CTRL, 32'h00, '0);
      power_good_in <= 1'b0;
      repeat (100) @(posedge hclk);
      power_good_in <= 1'b1;
      await_on(`RESTART_CYCLES);
      repeat (10) @(posedge hclk);
      chk("strap mode", 3'b001, {pll_low_bandwidth, pll_bypass, pll_high_bandwidth});
      power_cycle(1, 1, 1'b1, 1'b0);
      hold_off("no reference");
      ahb(1'b0, `REG_STATUS, 32'h2, 32'h3);
      ref_run <= 1'b1;
      await_on(900);
      wrap_up();
   end
   // Cuts a hang short.
   initial begin
      #1000000;
      n_fail++;
      $display("Error watchdog expected finish seen timeout");
      wrap_up();
   end
   task automatic wrap_up();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
endmodule
